// File: design/ddcs_defines.svh
`ifndef DDCS_DEFINES_SVH
`define DDCS_DEFINES_SVH

`define DDCS_ADDR_W          10
`define DDCS_OFS_ROUTING     10'h371
`define DDCS_OFS_NCO_CTRL    10'h374
`define DDCS_ROUTING_RESET   8'h05
`define DDCS_NCO_CTRL_RESET  8'h00
`define DDCS_ROUTING_WMASK   8'h05
`define DDCS_BIT_I_SEL       0
`define DDCS_BIT_Q_SEL       2
`define DDCS_MODE_MSB        7
`define DDCS_MODE_LSB        4
`define DDCS_CHAN_MSB        3
`define DDCS_CHAN_LSB        0

`endif

// File: design/ddcs_pkg.sv
package ddcs_pkg;
    typedef logic [3:0] ddcs_chan_t;
    typedef enum logic [3:0] {
        DDCS_MODE_REG      = 4'h0,
        DDCS_MODE_B0A0     = 4'h1,
        DDCS_MODE_B1A1     = 4'h2,
        DDCS_MODE_A1A0     = 4'h3,
        DDCS_MODE_B1B0     = 4'h4,
        DDCS_MODE_INTERLV  = 4'h5,
        DDCS_MODE_GROUPED  = 4'h6,
        DDCS_MODE_EDGE_A0  = 4'h8,
        DDCS_MODE_EDGE_A1  = 4'h9,
        DDCS_MODE_EDGE_B0  = 4'hA,
        DDCS_MODE_EDGE_B1  = 4'hB
    } ddcs_mode_t;
endpackage

// File: design/ddcs_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ddcs_sel_if;
    logic side_a_sel0;
    logic side_a_sel1;
    logic side_b_sel0;
    logic side_b_sel1;
    modport device (input side_a_sel0, side_a_sel1, side_b_sel0, side_b_sel1);
    modport ctrl   (output side_a_sel0, side_a_sel1, side_b_sel0, side_b_sel1);
endinterface
`default_nettype wire

// File: design/ddcs_device.sv
`include "ddcs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ddcs_device
    import ddcs_pkg::*;
#(
    parameter int SAMPLE_W = 16
)
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    sys_rst_i,
    ddcs_sel_if.device                   sel_if,
    input  wire logic                    reg_wr_i,
    input  wire logic [`DDCS_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    output logic      [7:0]              reg_rdata_o,
    input  wire logic [SAMPLE_W-1:0]     adc_a_i,
    input  wire logic [SAMPLE_W-1:0]     adc_b_i,
    output logic      [SAMPLE_W-1:0]     ddc_i_o,
    output logic      [SAMPLE_W-1:0]     ddc_q_o,
    output logic      [3:0]              nco_chan_o
);
    logic [7:0]          routing_reg;
    logic [7:0]          routing_next;
    logic [7:0]          nco_ctrl_reg;
    logic [7:0]          nco_ctrl_next;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;

    logic [3:0]          sync1_reg;
    logic [3:0]          sync1_next;
    logic [3:0]          sync2_reg;
    logic [3:0]          sync2_next;
    logic [3:0]          pins_d_reg;
    logic [3:0]          pins_d_next;

    logic [3:0]          counter_reg;
    logic [3:0]          counter_next;
    logic                edge_seen;

    ddcs_chan_t          chan_reg;
    ddcs_chan_t          chan_next;
    ddcs_mode_t          mode;
    ddcs_chan_t          reg_chan;

    logic [SAMPLE_W-1:0] i_reg;
    logic [SAMPLE_W-1:0] i_next;
    logic [SAMPLE_W-1:0] q_reg;
    logic [SAMPLE_W-1:0] q_next;

    // The address match is shared by the write path and the read path.
    function automatic logic addr_hit(
        input logic [`DDCS_ADDR_W-1:0] addr,
        input logic [`DDCS_ADDR_W-1:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction

    // Picks the pin that an edge-counting mode watches; every other mode watches none.
    function automatic logic edge_pin(input ddcs_mode_t m, input logic [3:0] v);
        edge_pin = 1'b0;
        unique case (m)
            DDCS_MODE_EDGE_A0: edge_pin = v[0];
            DDCS_MODE_EDGE_A1: edge_pin = v[1];
            DDCS_MODE_EDGE_B0: edge_pin = v[2];
            DDCS_MODE_EDGE_B1: edge_pin = v[3];
            default:           edge_pin = 1'b0;
        endcase
    endfunction

    // Pin order in sync vectors: {b1, b0, a1, a0}.
    always_comb begin
        sync1_next  = {sel_if.side_b_sel1, sel_if.side_b_sel0, sel_if.side_a_sel1, sel_if.side_a_sel0};
        sync2_next  = sync1_reg;
        pins_d_next = sync2_reg;
    end

    // Resetting to the idle low level keeps a false rising edge from following reset.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg  <= 4'h0;
            sync2_reg  <= 4'h0;
            pins_d_reg <= 4'h0;
        end else begin
            sync1_reg  <= sync1_next;
            sync2_reg  <= sync2_next;
            pins_d_reg <= pins_d_next;
        end
    end

    // Codes 7 and 12 to 15 name no mode, so they fall back to the register field.
    assign mode     = ddcs_mode_t'(nco_ctrl_reg[`DDCS_MODE_MSB:`DDCS_MODE_LSB]);
    assign reg_chan = nco_ctrl_reg[`DDCS_CHAN_MSB:`DDCS_CHAN_LSB];

    // Writes to any other address are dropped, and reads of it return zero.
    always_comb begin
        routing_next  = routing_reg;
        nco_ctrl_next = nco_ctrl_reg;
        rdata_next    = 8'h00;
        if (reg_wr_i && addr_hit(reg_addr_i, `DDCS_OFS_ROUTING)) begin
            // Only the two select bits are writable; the rest stay reserved zero.
            routing_next = reg_wdata_i & `DDCS_ROUTING_WMASK;
        end
        if (reg_wr_i && addr_hit(reg_addr_i, `DDCS_OFS_NCO_CTRL)) begin
            nco_ctrl_next = reg_wdata_i;
        end
        if (addr_hit(reg_addr_i, `DDCS_OFS_ROUTING)) begin
            rdata_next = routing_reg;
        end else if (addr_hit(reg_addr_i, `DDCS_OFS_NCO_CTRL)) begin
            rdata_next = nco_ctrl_reg;
        end
    end

    // Read data is registered, so it shows the addressed register one edge after the address.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            routing_reg  <= `DDCS_ROUTING_RESET;
            nco_ctrl_reg <= `DDCS_NCO_CTRL_RESET;
            rdata_reg    <= 8'h00;
        end else begin
            routing_reg  <= routing_next;
            nco_ctrl_reg <= nco_ctrl_next;
            rdata_reg    <= rdata_next;
        end
    end

    // An edge is a high synchronised sample after a low one, so each rising edge counts once.
    always_comb begin
        edge_seen    = edge_pin(mode, sync2_reg) && !edge_pin(mode, pins_d_reg);
        counter_next = counter_reg;
        if (edge_seen) begin
            // Wrapping on the programmed value keeps the index inside the active set.
            counter_next = (counter_reg >= reg_chan) ? 4'h0 : 4'(counter_reg + 4'h1);
        end
    end

    // A mode change does not clear the counter, so a new edge mode resumes from the old count.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            counter_reg <= 4'h0;
        end else begin
            counter_reg <= counter_next;
        end
    end

    // Level modes read the synchronised pins, so a pin change reaches the index three edges later.
    always_comb begin
        chan_next = reg_chan;
        unique case (mode)
            DDCS_MODE_REG:     chan_next = reg_chan;
            DDCS_MODE_B0A0:    chan_next = {2'b00, sync2_reg[2], sync2_reg[0]};
            DDCS_MODE_B1A1:    chan_next = {2'b00, sync2_reg[3], sync2_reg[1]};
            DDCS_MODE_A1A0:    chan_next = {2'b00, sync2_reg[1], sync2_reg[0]};
            DDCS_MODE_B1B0:    chan_next = {2'b00, sync2_reg[3], sync2_reg[2]};
            DDCS_MODE_INTERLV: chan_next = {sync2_reg[3], sync2_reg[1], sync2_reg[2], sync2_reg[0]};
            DDCS_MODE_GROUPED: chan_next = sync2_reg;
            DDCS_MODE_EDGE_A0,
            DDCS_MODE_EDGE_A1,
            DDCS_MODE_EDGE_B0,
            DDCS_MODE_EDGE_B1: chan_next = counter_reg;
            default:           chan_next = reg_chan;
        endcase
    end

    // The index is registered so that the oscillator sees it straight from a flip-flop.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chan_reg <= 4'h0;
        end else begin
            chan_reg <= chan_next;
        end
    end

    // Routed samples cost one cycle of latency but leave the block from flip-flops.
    always_comb begin
        i_next = routing_reg[`DDCS_BIT_I_SEL] ? adc_b_i : adc_a_i;
        q_next = routing_reg[`DDCS_BIT_Q_SEL] ? adc_b_i : adc_a_i;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            i_reg <= '0;
            q_reg <= '0;
        end else begin
            i_reg <= i_next;
            q_reg <= q_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign nco_chan_o  = chan_reg;
    assign ddc_i_o     = i_reg;
    assign ddc_q_o     = q_reg;
endmodule
`default_nettype wire

// File: design/ddcs_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_ctrl
    import ddcs_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] pins_i,
    ddcs_sel_if.ctrl        sel_if
);
    // Pin values {b1, b0, a1, a0} are registered so the pins change only on clock edges.
    logic [3:0] pins_reg;
    logic [3:0] pins_next;

    always_comb begin
        pins_next = pins_i;
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pins_reg <= 4'h0;
        end else begin
            pins_reg <= pins_next;
        end
    end

    assign sel_if.side_a_sel0 = pins_reg[0];
    assign sel_if.side_a_sel1 = pins_reg[1];
    assign sel_if.side_b_sel0 = pins_reg[2];
    assign sel_if.side_b_sel1 = pins_reg[3];
endmodule
`default_nettype wire

// File: dv/ddcs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ddcs_chk (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic [3:0] pins_i,
    input wire logic       reg_wr_i,
    input wire logic       side_a_sel0_i,
    input wire logic       side_a_sel1_i,
    input wire logic       side_b_sel0_i,
    input wire logic       side_b_sel1_i,
    input wire logic [3:0] nco_chan_i
);
    logic [3:0] pins;
    assign pins = {side_b_sel1_i, side_b_sel0_i, side_a_sel1_i, side_a_sel0_i};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    link_delay_a: assert property (pins == $past(pins_i)) else $error("pins lag");
    link_hold_a: assert property ($stable(pins_i) |=> $stable(pins)) else $error("pins moved");
    rise_a0_a: assert property ($rose(pins_i[0]) |=> $rose(side_a_sel0_i)) else $error("a0 rise");
    rise_a1_a: assert property ($rose(pins_i[1]) |=> $rose(side_a_sel1_i)) else $error("a1 rise");
    rise_b0_a: assert property ($rose(pins_i[2]) |=> $rose(side_b_sel0_i)) else $error("b0 rise");
    rise_b1_a: assert property ($rose(pins_i[3]) |=> $rose(side_b_sel1_i)) else $error("b1 rise");
    fall_b0_a: assert property ($fell(pins_i[2]) |=> !side_b_sel0_i) else $error("b0 fall");
    // Six quiet cycles cover the pin path plus the counter, so any change here is spurious.
    chan_quiet_a: assert property ((!reg_wr_i && $stable(pins_i))[*6] |-> $stable(nco_chan_i))
        else $error("chan moved");
endmodule
`default_nettype wire

// File: dv/ddc_input_and_nco_channel_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_input_and_nco_channel_select_test;
    import ddcs_pkg::*;
    logic       clk_sys_i   = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic       reg_wr_i    = 1'b0;
    logic [9:0] reg_addr_i  = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [3:0] pins_i      = 4'h0;
    logic [7:0] reg_rdata_o;
    logic [15:0] ddc_i_o;
    logic [15:0] ddc_q_o;
    ddcs_chan_t nco_chan_o;
    int         mismatches  = 0;
    int         checked     = 0;
    ddcs_sel_if sel_if ();
    ddcs_ctrl i_ddcs_ctrl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins_i(pins_i), .sel_if(sel_if));
    ddcs_device i_ddcs_device (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sel_if(sel_if), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .adc_a_i(16'h1234),
        .adc_b_i(16'hABCD), .ddc_i_o(ddc_i_o), .ddc_q_o(ddc_q_o), .nco_chan_o(nco_chan_o));
    ddcs_chk i_ddcs_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins_i(pins_i), .reg_wr_i(reg_wr_i),
        .side_a_sel0_i(sel_if.side_a_sel0), .side_a_sel1_i(sel_if.side_a_sel1),
        .side_b_sel0_i(sel_if.side_b_sel0), .side_b_sel1_i(sel_if.side_b_sel1),
        .nco_chan_i(nco_chan_o));
    always #5 clk_sys_i = ~clk_sys_i;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Writes leave six edges so pin-derived channels have settled before any check.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        repeat (2) @(posedge clk_sys_i);
        cmp({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask
    function automatic ddcs_chan_t pick(input logic [3:0] m, input logic [3:0] p);
        case (m)
            4'h1: pick = {2'b00, p[2], p[0]};
            4'h2: pick = {2'b00, p[3], p[1]};
            4'h3: pick = {2'b00, p[1], p[0]};
            4'h4: pick = {2'b00, p[3], p[2]};
            4'h5: pick = {p[3], p[1], p[2], p[0]};
            default: pick = p;
        endcase
    endfunction
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(10'h371, 8'h05);
        rd(10'h374, 8'h00);
        rd(10'h372, 8'h00);
        cmp(ddc_i_o, 16'hABCD);
        wr(10'h371, 8'hFE);
        rd(10'h371, 8'h04);
        cmp(ddc_i_o, 16'h1234);
        cmp(ddc_q_o, 16'hABCD);
        wr(10'h371, 8'h01);
        rd(10'h371, 8'h01);
        cmp(ddc_i_o, 16'hABCD);
        cmp(ddc_q_o, 16'h1234);
        for (int c = 0; c < 16; c++) begin
            wr(10'h374, 8'(c));
            cmp({12'h000, nco_chan_o}, 16'(c));
        end
        for (int m = 1; m < 7; m++) begin
            pins_i <= 4'(m + 8);
            wr(10'h374, {4'(m), 4'h0});
            cmp({12'h000, nco_chan_o}, {12'h000, pick(4'(m), 4'(m + 8))});
        end
        pins_i <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            wr(10'h374, {4'(k + 8), 4'h2});
            for (int n = 1; n < 4; n++) begin
                pins_i[k] <= 1'b1;
                repeat (6) @(posedge clk_sys_i);
                pins_i[k] <= 1'b0;
                repeat (6) @(posedge clk_sys_i);
                cmp({12'h000, nco_chan_o}, 16'(n % 3));
            end
        end
        // Undefined mode codes fall back to the register field.
        wr(10'h374, 8'h75);
        cmp({12'h000, nco_chan_o}, 16'h0005);
        wr(10'h374, 8'hC9);
        cmp({12'h000, nco_chan_o}, 16'h0009);
        // A field of zero holds the counter at zero.
        wr(10'h374, 8'h80);
        pins_i[0] <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        pins_i[0] <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        cmp({12'h000, nco_chan_o}, 16'h0000);
        wr(10'h374, 8'h83);
        pins_i[0] <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        pins_i[0] <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        cmp({12'h000, nco_chan_o}, 16'h0001);
        // A reset in mid-run must clear the counter and return both registers to their reset values.
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(10'h374, 8'h00);
        rd(10'h371, 8'h05);
        wr(10'h374, 8'h82);
        cmp({12'h000, nco_chan_o}, 16'h0000);
        stop_test;
    end
endmodule
`default_nettype wire
